/* hw/fdc_regs_cfg.svh */
// Offsets, field positions, reset values and timing for the FDC
// drive/media type and main status registers.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FDC_REGS_CFG_SVH
`define FDC_REGS_CFG_SVH

// Register addresses on the 3-bit FDC address (A2..A0)
`define ADDR_DRIVE_MEDIA_TYPE 3'h3
`define ADDR_MAIN_STATUS      3'h4

// Drive/media type register fields
`define DMT_TAPE_LSB      0
`define DMT_EXCH_LSB      2
`define DMT_RSVD_BIT      4
`define DMT_VALID_BIT     5
`define DMT_HD_BIT        6
`define DMT_ED_BIT        7

// Exchange field encodings
`define EXCH_NONE         2'h0
`define EXCH_0_1          2'h1
`define EXCH_0_2          2'h2

// Main status register fields
`define MS_REQ_BIT        7
`define MS_DIR_BIT        6
`define MS_NONDMA_BIT     5
`define MS_CIP_BIT        4

// Reset and ready values
`define MS_RESET_VAL      8'h00
`define MS_READY_VAL      8'h80
`define DMT_RSVD_VAL      1'h1

// Worst-case time to ready after reset, in ns, at a 100 ns clock
`define READY_TIME_NS     2500
`define CLK_PERIOD_NS     100
`define READY_CYCLES      (`READY_TIME_NS / `CLK_PERIOD_NS)

`endif

/* hw/fdc_regs_pkg.sv */
// Types shared by the FDC drive/media type and main status logic.
// Assumes the constants header sits beside it on the include path.
package fdc_regs_pkg;
  `include "fdc_regs_cfg.svh"

  // Operating mode of the drive/media type register
  typedef enum logic [1:0] {
    MODE_COMPAT,
    MODE_MEDIA_SENSE,
    MODE_ENHANCED
  } dmt_mode_t;

  // Initialisation sequencer after any reset
  typedef enum logic [0:0] {
    INIT_WAIT,
    INIT_DONE
  } init_state_t;
endpackage

/* hw/fdc_type_status.sv */
// FDC drive/media type register and main status register.
// Assumes a host read/write strobe on the same clock, controller core
// events as one-cycle pulses, and configuration bits from elsewhere.
`timescale 1ns/1ps

`include "fdc_regs_cfg.svh"

// Limitations and hazards:
// - Compatible-mode type reads return bits 7..2 as zero; the lane
//   enable is shared, so the bus must treat those bits as floating.
// - Reserved exchange code 11 is decoded as no remap, a safe fallback
//   for a value that software must never program.
// - Drive 2 and 3 pins stay low unless four-drive encoding is on,
//   since they need external decode logic to be of use.
// - Busy and command flags favour the set when set and clear meet,
//   so a seek issued in the sense cycle is never lost.
// - Software reset restarts the init counter and clears command
//   status; type fields and pin routing survive it.
// - Media id bits pass two flops, so a media change shows on a
//   type read two to three clocks later.
// - Status needs READY_CYC clocks after any reset before 80h shows.
// - Pins follow the internal selects one clock late.
// - Exchange writes land only in enhanced mode.

module fdc_type_status
  import fdc_regs_pkg::*;
#(
  parameter int READY_CYC = `READY_CYCLES
) (
  // Clock and resets
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       soft_rst_in,
  // Host register access
  input  wire logic [2:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  output logic            rdata_oe_out,
  // Configuration bits
  input  wire logic       function_control_reg_in,
  input  wire logic       aux_setup_config_in,
  input  wire logic       media_sense_cfg_in,
  input  wire logic       four_drive_encoding_in,
  input  wire logic       valid_flag_0_in,
  input  wire logic       valid_flag_1_in,
  // Media sense pins
  input  wire logic       media_sense_in_0,
  input  wire logic       media_sense_in_1,
  // Controller core status and events
  input  wire logic       core_ready_in,
  input  wire logic       core_dir_read_in,
  input  wire logic       nondma_exec_in,
  input  wire logic       ctrl_irq_in,
  input  wire logic       data_xfer_in,
  input  wire logic       cmd_first_in,
  input  wire logic       cmd_end_in,
  input  wire logic       seek_done_in,
  input  wire logic       sense_first_in,
  input  wire logic [1:0] seek_drive_in,
  // Internal drive select and motor signals
  input  wire logic [3:0] drv_sel_int_in,
  input  wire logic [3:0] motor_int_in,
  // Drive pins after exchange, and tape assignment
  output logic            drive_select_out_0,
  output logic            drive_select_out_1,
  output logic            drive_select_out_2,
  output logic            drive_select_out_3,
  output logic            motor_out_0,
  output logic            motor_out_1,
  output logic            motor_out_2,
  output logic            motor_out_3,
  output logic      [1:0] tape_drive_out
);

  // Counter wide enough to hold READY_CYC - 1
  localparam int CW = $clog2(READY_CYC + 1);

  // Whole module state
  typedef struct packed {
    // Two-flop synchronisers for the media sense pins
    logic [1:0]  ms0;
    logic [1:0]  ms1;
    // Host-written type fields
    logic [1:0]  tape_sel;
    logic [1:0]  exch;
    // Initialisation sequencer and its counter
    init_state_t init;
    logic [CW-1:0] cnt;
    // Status flags
    logic        req_hold;
    logic        cip;
    logic [3:0]  busy;
    // Registered read lane
    logic [7:0]  rdata;
    logic        oe;
    // Drive pins after exchange
    logic [3:0]  ds;
    logic [3:0]  mt;
  } state_t;

  // Current and next copies of all state
  state_t st_reg;
  state_t st_next;

  // Mode from the two configuration bits
  // Setup bit wins over the control bit
  function automatic dmt_mode_t mode_of(input logic fc0, input logic asc2);
    if (asc2) begin
      mode_of = MODE_ENHANCED;
    end else if (fc0) begin
      mode_of = MODE_COMPAT;
    end else begin
      mode_of = MODE_MEDIA_SENSE;
    end
  endfunction

  // One-hot decode of a drive number
  function automatic logic [3:0] drv_hot(input logic [1:0] d);
    drv_hot = 4'h1 << d;
  endfunction

  // Exchange remap of one four-wire pin group
  // Codes 00 and reserved 11 leave pins unmapped
  function automatic logic [3:0] exch_map(input logic [1:0] sel,
                                          input logic [3:0] v,
                                          input logic       four);
    exch_map = v;
    if (sel == `EXCH_0_1) begin
      exch_map[0] = v[1];
      exch_map[1] = v[0];
    end else if (sel == `EXCH_0_2) begin
      exch_map[0] = v[2];
    end
    if (!four) begin
      exch_map[3:2] = 2'h0;
    end
  endfunction

  // Decode helpers
  dmt_mode_t   mode;
  // Address hits
  logic        is_dmt;
  logic        is_ms;
  // Assembled read values
  logic        valid_n;
  logic [7:0]  dmt_val;
  logic [7:0]  ms_val;
  // Exchange actually applied and drive decode for seek and sense
  logic [1:0]  eff_exch;
  logic [3:0]  seek_hot;

  // Next state
  always_comb begin
    st_next = st_reg;
    mode = mode_of(function_control_reg_in, aux_setup_config_in);
    is_dmt = (addr_in == `ADDR_DRIVE_MEDIA_TYPE);
    is_ms  = (addr_in == `ADDR_MAIN_STATUS);
    seek_hot = drv_hot(seek_drive_in);

    // Media sense pins through two flops
    // Only the second flop feeds the read value
    st_next.ms0 = {st_reg.ms0[0], media_sense_in_0};
    st_next.ms1 = {st_reg.ms1[0], media_sense_in_1};

    // Valid flag follows the drive being accessed
    // Flags are active low; drive 0 wins if both selects show
    valid_n = 1'h1;
    if (media_sense_cfg_in && drv_sel_int_in[0]) begin
      valid_n = valid_flag_0_in;
    end else if (media_sense_cfg_in && drv_sel_int_in[1]) begin
      valid_n = valid_flag_1_in;
    end
    if (mode == MODE_COMPAT && four_drive_encoding_in) begin
      valid_n = 1'h1;
    end

    // Read value per mode; media id encoded by the sensed pin levels
    // Bit 4 is reserved and reads 1 in enhanced mode
    dmt_val = 8'h00;
    dmt_val[`DMT_TAPE_LSB +: 2] = st_reg.tape_sel;
    if (mode != MODE_COMPAT) begin
      dmt_val[`DMT_ED_BIT]    = st_reg.ms1[1];
      dmt_val[`DMT_HD_BIT]    = st_reg.ms0[1];
      dmt_val[`DMT_VALID_BIT] = valid_n;
    end
    if (mode == MODE_ENHANCED) begin
      dmt_val[`DMT_RSVD_BIT] = `DMT_RSVD_VAL;
      dmt_val[`DMT_EXCH_LSB +: 2] = st_reg.exch;
    end

    // Register writes; exchange field only in enhanced mode
    // Tape select lands in every mode
    if (wr_in && is_dmt) begin
      st_next.tape_sel = wdata_in[`DMT_TAPE_LSB +: 2];
      if (mode == MODE_ENHANCED) begin
        st_next.exch = wdata_in[`DMT_EXCH_LSB +: 2];
      end
    end

    // Initialisation: status holds 00h until the counter expires
    // Counter stops at READY_CYC - 1, so it never wraps
    case (st_reg.init)
      INIT_WAIT: begin
        if (st_reg.cnt == CW'(READY_CYC - 1)) begin
          st_next.init = INIT_DONE;
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      INIT_DONE: begin
        st_next.init = INIT_DONE;
      end
      default: st_next.init = INIT_WAIT;
    endcase

    // Outside non-DMA execution, request drops on each data byte, returns once core ready has dropped and risen again
    // The hold masks the request from the transfer edge until the
    // core shows it has taken or produced the byte
    if (data_xfer_in) begin
      st_next.req_hold = 1'h1;
    end else if (!core_ready_in) begin
      st_next.req_hold = 1'h0;
    end

    // Command in progress; set wins over clear
    // A command that starts and ends in one cycle stays in progress
    if (cmd_first_in) begin
      st_next.cip = 1'h1;
    end else if (cmd_end_in) begin
      st_next.cip = 1'h0;
    end

    // Per-drive busy; set wins over clear
    // A seek in the sense cycle is kept, not lost
    for (int i = 0; i < 4; i++) begin
      if (seek_done_in && seek_hot[i]) begin
        st_next.busy[i] = 1'h1;
      end else if (sense_first_in && seek_hot[i]) begin
        st_next.busy[i] = 1'h0;
      end
    end

    // Status byte, valid at every read
    // Outside non-DMA execution the live transfer strobe also masks the
    // request, so a status read in the transfer cycle already shows it clear
    ms_val = `MS_RESET_VAL;
    if (st_reg.init == INIT_DONE) begin
      if (nondma_exec_in) begin
        ms_val[`MS_REQ_BIT] = ctrl_irq_in;
      end else begin
        ms_val[`MS_REQ_BIT] = core_ready_in && !st_reg.req_hold
          && !data_xfer_in;
      end
      ms_val[`MS_DIR_BIT]    = core_dir_read_in;
      ms_val[`MS_NONDMA_BIT] = nondma_exec_in;
      ms_val[`MS_CIP_BIT]    = st_reg.cip;
      ms_val[3:0]            = st_reg.busy;
    end

    // Read data; compatible mode returns bits 7..2 as zero under the shared lane enable
    // Lane enable is a one-cycle pulse; the bus sees zero otherwise
    st_next.oe = 1'h0;
    st_next.rdata = 8'h00;
    if (rd_in && is_ms) begin
      st_next.rdata = ms_val;
      st_next.oe = 1'h1;
    end else if (rd_in && is_dmt) begin
      st_next.rdata = dmt_val;
      st_next.oe = 1'h1;
    end

    // Drive exchange, ignored with four-drive encoding
    // Same remap for selects and motors keeps each pair together
    eff_exch = four_drive_encoding_in ? `EXCH_NONE : st_reg.exch;
    st_next.ds = exch_map(eff_exch, drv_sel_int_in, four_drive_encoding_in);
    st_next.mt = exch_map(eff_exch, motor_int_in, four_drive_encoding_in);

    // Software reset restarts init and clears command status
    // Type fields and pin routing are left as the host set them
    if (soft_rst_in) begin
      st_next.init = INIT_WAIT;
      st_next.cnt = '0;
      st_next.cip = 1'h0;
      st_next.busy = 4'h0;
      st_next.req_hold = 1'h0;
    end
  end

  // State register
  // Asynchronous reset loads constants only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops; bits 7..2 driven as zero in compatible mode
  // Host read lane
  assign rdata_out          = st_reg.rdata;
  assign rdata_oe_out       = st_reg.oe;
  // Drive select pins
  assign drive_select_out_0 = st_reg.ds[0];
  assign drive_select_out_1 = st_reg.ds[1];
  assign drive_select_out_2 = st_reg.ds[2];
  assign drive_select_out_3 = st_reg.ds[3];
  // Motor pins
  assign motor_out_0        = st_reg.mt[0];
  assign motor_out_1        = st_reg.mt[1];
  assign motor_out_2        = st_reg.mt[2];
  assign motor_out_3        = st_reg.mt[3];
  // Tape assignment
  assign tape_drive_out     = st_reg.tape_sel;

endmodule

/* dv/fdc_type_status_assertions.sv */
// Checker for the drive type and main status block.
// Assumes it is bound to fdc_type_status and sees only its ports.
`timescale 1ns/1ps
module fdc_type_status_assertions #(
  parameter int READY_CYC = 25
) (
  // Clock, resets and host strobes
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       soft_rst_in,
  input wire logic [2:0] addr_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rdata_oe_out,
  // Configuration and core status
  input wire logic       function_control_reg_in,
  input wire logic       aux_setup_config_in,
  input wire logic       four_drive_encoding_in,
  input wire logic       core_dir_read_in,
  input wire logic       nondma_exec_in,
  input wire logic       data_xfer_in,
  // Drive selects and tape field
  input wire logic [3:0] drv_sel_int_in,
  input wire logic       drive_select_out_0,
  input wire logic       drive_select_out_1,
  input wire logic [1:0] tape_drive_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] init_cnt;
  logic [1:0] exch_q;
  wire st_rd = rd_in && addr_in == 3'h4;
  wire ty_rd = rd_in && addr_in == 3'h3;
  wire rdy   = init_cnt > READY_CYC + 2 && !soft_rst_in;
  wire keep  = four_drive_encoding_in || exch_q[0] == exch_q[1];
  // Shadow of init time and exchange field; only enhanced writes land
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt <= 6'h0;
      exch_q   <= 2'h0;
    end else begin
      if (soft_rst_in)
        init_cnt <= 6'h0;
      else if (init_cnt != 6'h3f)
        init_cnt <= init_cnt + 6'h1;
      if (wr_in && addr_in == 3'h3 && aux_setup_config_in)
        exch_q <= wdata_in[3:2];
    end
  end
  property p_oe;
    st_rd || ty_rd |=> rdata_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("no read answer");
  property p_init;
    st_rd && init_cnt + 2 < READY_CYC |=> rdata_out == 8'h00;
  endproperty
  a_init: assert property (p_init) else $error("early status");
  property p_xfer;
    st_rd && data_xfer_in && !nondma_exec_in |=> !rdata_out[7];
  endproperty
  a_xfer: assert property (p_xfer) else $error("request kept");
  property p_dirnd;
    st_rd && rdy |=> rdata_out[6] == $past(core_dir_read_in)
      && rdata_out[5] == $past(nondma_exec_in);
  endproperty
  a_dirnd: assert property (p_dirnd) else $error("dir bits");
  property p_compat;
    ty_rd && function_control_reg_in && !aux_setup_config_in
      |=> rdata_out[7:2] == 6'h0 && rdata_out[1:0] == tape_drive_out;
  endproperty
  a_compat: assert property (p_compat) else $error("compat read");
  property p_tape;
    wr_in && addr_in == 3'h3 |=> tape_drive_out == $past(wdata_in[1:0]);
  endproperty
  a_tape: assert property (p_tape) else $error("tape field");
  property p_swap;
    !four_drive_encoding_in && exch_q == 2'h1 |=>
      {drive_select_out_0, drive_select_out_1} == $past(drv_sel_int_in[1:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("swap 0 1");
  property p_keep;
    keep |=> drive_select_out_0 == $past(drv_sel_int_in[0])
      && drive_select_out_1 == $past(drv_sel_int_in[1]);
  endproperty
  a_keep: assert property (p_keep) else $error("remap");
endmodule
bind fdc_type_status fdc_type_status_assertions #(.READY_CYC(READY_CYC))
  chk_u (.*);

/* dv/fdc_host_model.sv */
// Host processor model: register reads and writes on the strobes.
// Assumes the block clock; changes lines on falling edges only.
`timescale 1ns/1ps
module fdc_host_model (
  // Clock and answer
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       oe_in,
  // Strobes, address and data
  output logic      [2:0] addr_out = 3'h7,
  output logic            rd_out = 1'b0,
  output logic            wr_out = 1'b0,
  output logic            xfer_out = 1'b0,
  output logic      [7:0] wdata_out = 8'h00
);
  // One read; answer taken once oe shows, two edges at most
  task automatic rd_reg(input logic [2:0] a, input logic x,
                        output logic [7:0] d);
    int n;
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    xfer_out = x;
    @(negedge clk_in);
    rd_out = 1'b0;
    xfer_out = 1'b0;
    addr_out = 3'h7;
    n = 0;
    while (oe_in !== 1'b1 && n < 2) begin
      @(negedge clk_in);
      n++;
    end
    d = (oe_in === 1'b1) ? rdata_in : 8'hxx;
  endtask
  // One write; data inverted after so a stale byte never looks valid
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = 3'h7;
    wdata_out = ~d;
  endtask
  // Data byte: status polled first, then the transfer itself
  task automatic xfer_byte(output logic [7:0] s0, s1);
    rd_reg(3'h4, 1'b0, s0);
    rd_reg(3'h4, 1'b1, s1);
  endtask
endmodule

/* dv/tb_top.sv */
// Bench for the drive type and main status block.
// Assumes the host model beside it and a 100 ns clock.
`timescale 1ns/1ps
module tb_top;
  localparam int RC = 4;
  // Inputs, changed on falling edges
  logic sys_clk_in = 0, rst_in = 1, soft_rst_in = 0;
  logic function_control_reg_in = 0, aux_setup_config_in = 0;
  logic media_sense_cfg_in = 0, four_drive_encoding_in = 0;
  logic valid_flag_0_in = 0, valid_flag_1_in = 0, core_ready_in = 1;
  logic media_sense_in_0 = 0, media_sense_in_1 = 0, core_dir_read_in = 0;
  logic nondma_exec_in = 0, ctrl_irq_in = 0;
  logic [1:0] seek_drive_in = 0;
  logic [3:0] drv_sel_int_in = 0, motor_int_in = 0, ev = 0;
  // Nets from host model and block
  wire [2:0] addr_in;
  wire [7:0] wdata_in, rdata_out;
  wire       rd_in, wr_in, data_xfer_in, rdata_oe_out;
  wire       cmd_first_in, cmd_end_in, seek_done_in, sense_first_in;
  wire       drive_select_out_0, drive_select_out_1, drive_select_out_2;
  wire       drive_select_out_3, motor_out_0, motor_out_1, motor_out_2;
  wire       motor_out_3;
  wire [1:0] tape_drive_out;
  wire [7:0] pins = {drive_select_out_3, drive_select_out_2,
    drive_select_out_1, drive_select_out_0, motor_out_3, motor_out_2,
    motor_out_1, motor_out_0};
  int fail_count = 0, compares = 0, cyc = 0;
  logic [7:0] r, r2;
  assign {cmd_first_in, cmd_end_in, seek_done_in, sense_first_in} = ev;
  fdc_type_status #(.READY_CYC(RC)) dut_u (.*);
  fdc_host_model host_u (.clk_in(sys_clk_in), .rdata_in(rdata_out),
    .oe_in(rdata_oe_out), .addr_out(addr_in), .rd_out(rd_in),
    .wr_out(wr_in), .xfer_out(data_xfer_in), .wdata_out(wdata_in));
  // Clock and hang guard; a run of about 130 cycles is expected
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      test_done;
    end
  end
  task automatic test_done;
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, g, m);
    compares++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic rs(logic [2:0] a, logic [7:0] e, m, string n);
    host_u.rd_reg(a, 1'b0, r);
    chk(n, e, r, m);
  endtask
  task automatic pulse(logic [3:0] v, logic [1:0] d);
    @(negedge sys_clk_in);
    ev = v;
    seek_drive_in = d;
    @(negedge sys_clk_in);
    ev = 4'h0;
  endtask
  task automatic t_init;
    rs(3'h4, 8'h00, 8'hff, "status");
    tick(RC + 2);
    rs(3'h4, 8'h80, 8'hff, "status");
  endtask
  task automatic t_type;
    aux_setup_config_in = 1;
    media_sense_cfg_in = 1;
    media_sense_in_1 = 1;
    drv_sel_int_in = 4'h1;
    host_u.wr_reg(3'h3, 8'h02);
    tick(4);
    rs(3'h3, 8'h92, 8'hff, "type");
    aux_setup_config_in = 0;
    rs(3'h3, 8'h82, 8'he3, "type");
    {media_sense_in_1, media_sense_in_0, valid_flag_0_in} = 3'h3;
    drv_sel_int_in = 4'h2;
    tick(4);
    rs(3'h3, 8'h42, 8'he3, "type");
    media_sense_cfg_in = 0;
    rs(3'h3, 8'h22, 8'h23, "type");
    function_control_reg_in = 1;
    rs(3'h3, 8'h02, 8'hff, "type");
    for (int i = 0; i < 4; i++) begin
      host_u.wr_reg(3'h3, 8'(i));
      chk("tape", 8'(i), {6'h0, tape_drive_out}, 8'h03);
    end
  endtask
  task automatic sw(logic [1:0] e, logic f, logic [3:0] d, m, logic [7:0] x);
    host_u.wr_reg(3'h3, {4'h0, e, 2'h0});
    four_drive_encoding_in = f;
    {drv_sel_int_in, motor_int_in} = {d, m};
    tick(2);
    chk("pins", x, pins, 8'hff);
  endtask
  task automatic t_swap;
    {function_control_reg_in, aux_setup_config_in} = 2'h1;
    sw(2'h1, 0, 4'h1, 4'h2, 8'h21);
    sw(2'h2, 0, 4'h4, 4'h4, 8'h11);
    sw(2'h0, 0, 4'h2, 4'h8, 8'h20);
    sw(2'h0, 0, 4'h1, 4'h2, 8'h12);
    sw(2'h1, 1, 4'h8, 4'h1, 8'h81);
    four_drive_encoding_in = 0;
  endtask
  task automatic t_status;
    core_dir_read_in = 1;
    rs(3'h4, 8'hc0, 8'he0, "status");
    host_u.xfer_byte(r, r2);
    chk("status", 8'hc0, r, 8'hc0);
    chk("status", 8'h40, r2, 8'hc0);
    rs(3'h4, 8'h40, 8'hc0, "status");
    core_ready_in = 0;
    tick(1);
    core_ready_in = 1;
    rs(3'h4, 8'hc0, 8'hc0, "status");
    {core_dir_read_in, nondma_exec_in} = 2'h1;
    rs(3'h4, 8'h20, 8'he0, "status");
    ctrl_irq_in = 1;
    rs(3'h4, 8'ha0, 8'he0, "status");
    {nondma_exec_in, ctrl_irq_in} = 2'h0;
  endtask
  task automatic t_cmd;
    pulse(4'h8, 2'h0);
    rs(3'h4, 8'h10, 8'h1f, "status");
    for (int i = 0; i < 4; i++) pulse(4'h2, 2'(i));
    rs(3'h4, 8'h1f, 8'h1f, "status");
    pulse(4'h4, 2'h0);
    rs(3'h4, 8'h0f, 8'h1f, "status");
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1, 2'(i));
      rs(3'h4, {4'h0, 4'he << i}, 8'h1f, "status");
    end
  endtask
  task automatic t_soft;
    pulse(4'h2, 2'h1);
    host_u.wr_reg(3'h3, 8'h03);
    @(negedge sys_clk_in);
    soft_rst_in = 1;
    @(negedge sys_clk_in);
    soft_rst_in = 0;
    rs(3'h4, 8'h00, 8'hff, "status");
    chk("tape", 8'h03, {6'h0, tape_drive_out}, 8'h03);
    tick(RC + 2);
    rs(3'h4, 8'h80, 8'hff, "status");
  endtask
  // Reset for 8 cycles, then each scenario in turn
  initial begin
    tick(8);
    rst_in = 0;
    t_init;
    t_type;
    t_swap;
    t_status;
    t_cmd;
    t_soft;
    test_done;
  end
endmodule
